// [bench/vlc_compositor_tb_top.sv]
// Self-checking bench for the compositor with one extra stream layer fed but never enabled.
// Assumes the register offsets of vlc_map.svh and the sink model in this folder.
`timescale 1ns/10ps
`include "vlc_map.svh"
module vlc_compositor_tb_top;
  // ------------------------------------------------
  // Signals
  // ------------------------------------------------
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [23:0] sData = '0;
  logic sValid = 1'b0, sUser = 1'b0, sLast = 1'b0, sReady;
  logic [23:0] mData;
  logic mValid, mReady, mUser, mLast, holdOff = 1'b0;
  logic [0:0] elReady;
  logic [31:0] elData = '0;
  logic elValid = 1'b0, elUser = 1'b0, elLast = 1'b0;
  logic [3:0] wstrb = 4'hF;
  logic [15:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, showPix = 1'b0;
  logic [1:0] bresp, rresp;
  logic [23:0] bgPix = '0;
  logic [25:0] expQ[$];
  int num_errors = 0, num_checks = 0, seed = 5, taken = 0, t0 = 0;
  always #2 ref_clk = ~ref_clk;
  vlc_compositor #(.NL(2), .MAX_BEATS(64), .LOGO_W(8), .LOGO_H(8)) u_vlc_compositor (
    .ref_clk(ref_clk), .rst_n(rst_n),
    .s_axis_tdata(sData), .s_axis_tvalid(sValid), .s_axis_tready(sReady),
    .s_axis_tuser(sUser), .s_axis_tlast(sLast),
    .extra_layer_stream_in_tdata(elData), .extra_layer_stream_in_tvalid(elValid),
    .extra_layer_stream_in_tready(elReady), .extra_layer_stream_in_tuser(elUser),
    .extra_layer_stream_in_tlast(elLast),
    .m_axis_tdata(mData), .m_axis_tvalid(mValid), .m_axis_tready(mReady),
    .m_axis_tuser(mUser), .m_axis_tlast(mLast),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );
  vlc_sink_model u_vlc_sink_model (
    .clk(ref_clk), .rstN(rst_n), .holdOff(holdOff), .tdata(mData),
    .tvalid(mValid), .tready(mReady), .tuser(mUser), .tlast(mLast)
  );
  // ------------------------------------------------
  // Checking and closing
  // ------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic tmo();
    num_errors++;
    $display("wrong value at %0t: wait ran out", $time);
    tally_and_finish();
  endtask
  // ------------------------------------------------
  // Register bus master
  // ------------------------------------------------
  task automatic axiWr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        chk(32'(bresp), 32'(er), "write response");
        break;
      end
    end
    if (n == 50) tmo();
  endtask
  task automatic axiRd(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        chk(rdata, ed, "read data");
        chk(32'(rresp), 32'(er), "read response");
        break;
      end
    end
    if (n == 50) tmo();
  endtask
  // ------------------------------------------------
  // Primary stream source and reference model
  // ------------------------------------------------
  task automatic sendLine(input int n, input logic sof);
    int i, k, z, run;
    for (i = 0; i < n; i++) begin
      sData <= 24'($random(seed));
      sUser <= sof && i == 0;
      sLast <= i == n - 1;
      sValid <= 1'b1;
      for (k = 0; k < 300; k++) begin
        @(posedge ref_clk);
        if (sReady === 1'b1) break;
      end
      if (k == 300) tmo();
      taken++;
      // Full alpha passes the pixel unchanged; zero alpha or no layer shows background.
      expQ.push_back({sUser, sLast, showPix ? sData : bgPix});
      if (i < n - 1 && $random(seed) % 3 == 0) begin
        sValid <= 1'b0;
        @(posedge ref_clk);
      end
    end
    sValid <= 1'b0;
    z = 0;
    run = 0;
    // Sink stalls may delay the line end, so the last low run of ready is measured.
    for (k = 0; k < 20; k++) begin
      @(posedge ref_clk);
      if (sReady !== 1'b1) begin
        run++;
      end else begin
        if (run > 0) z = run;
        run = 0;
      end
    end
    chk(32'(z), 32'(`VLC_FLUSH_CYC), "ready during flush");
  endtask
  task automatic drain();
    int k;
    for (k = 0; k < 500 && u_vlc_sink_model.got.size() < expQ.size(); k++) begin
      @(posedge ref_clk);
    end
    if (k == 500) tmo();
    while (expQ.size() > 0) begin
      chk(32'(u_vlc_sink_model.got.pop_front()), 32'(expQ.pop_front()), "beat");
    end
    repeat (2) @(posedge ref_clk);
    chk(32'(mValid), 32'h0, "valid after drain");
  endtask
  // ------------------------------------------------
  // Main sequence
  // ------------------------------------------------
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    elData <= 32'($random(seed));
    elValid <= 1'b1;
    elUser <= 1'b1;
    elLast <= 1'b1;
    repeat (2) @(posedge ref_clk);
    axiRd(`VLC_CTRL_OFS, `VLC_REG_RST, `VLC_RESP_OK);
    chk(32'(elReady), 32'h0, "extra layer ready while full");
    axiWr(`VLC_BG01_OFS, 32'h0055_00A3, `VLC_RESP_OK);
    axiWr(`VLC_BG2_OFS, 32'h0000_003C, `VLC_RESP_OK);
    axiRd(`VLC_BG01_OFS, 32'h0055_00A3, `VLC_RESP_OK);
    axiWr(`VLC_REGS_END, 32'h0000_0001, `VLC_RESP_ERR);
    axiRd(`VLC_REGS_END, 32'h0000_0000, `VLC_RESP_ERR);
    wstrb <= 4'h5;
    axiWr(`VLC_KEY_OFS, 32'h1122_3344, `VLC_RESP_OK);
    wstrb <= 4'hF;
    axiRd(`VLC_KEY_OFS, 32'h0022_0044, `VLC_RESP_OK);
    axiWr(`VLC_LCFG_OFS, 32'h0000_00FF, `VLC_RESP_OK);
    axiWr(`VLC_LEN_OFS, 32'h0000_0001, `VLC_RESP_OK);
    axiWr(`VLC_CTRL_OFS, 32'h0000_0001, `VLC_RESP_OK);
    bgPix = 24'h3C55A3;
    showPix = 1'b1;
    sendLine(16, 1'b1);
    drain();
    t0 = taken;
    holdOff <= 1'b1;
    fork
      sendLine(10, 1'b0);
      begin
        repeat (30) @(posedge ref_clk);
        chk(32'(taken - t0 <= 4 && taken > t0), 32'h1, "intake while held");
        chk(32'(mValid), 32'h1, "output held");
        holdOff <= 1'b0;
      end
    join
    drain();
    axiWr(`VLC_LCFG_OFS, 32'h0000_0000, `VLC_RESP_OK);
    showPix = 1'b0;
    sendLine(8, 1'b0);
    drain();
    axiWr(`VLC_LEN_OFS, 32'h0000_0000, `VLC_RESP_OK);
    sendLine(8, 1'b0);
    drain();
    rst_n <= 1'b0;
    @(posedge ref_clk);
    chk(32'({sReady, mValid, awready, arready, elReady}), 32'h0, "outputs in reset");
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    axiRd(`VLC_LCFG_OFS, `VLC_REG_RST, `VLC_RESP_OK);
    tally_and_finish();
  end
endmodule

// [bench/vlc_sink_model.sv]
// Downstream video sink model that captures every composite beat it takes.
// Assumes one clock shared with the compositor, sampled on its rising edge.
`timescale 1ns/10ps
module vlc_sink_model (
  input wire logic clk,
  input wire logic rstN,
  input wire logic holdOff,
  input wire logic [23:0] tdata,
  input wire logic tvalid,
  output logic tready,
  input wire logic tuser,
  input wire logic tlast
);
  // ------------------------------------------------
  // Capture and ready pacing
  // ------------------------------------------------
  int seed = 5;
  logic [25:0] got[$];
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      tready <= 1'b0;
    end else begin
      if (tvalid && tready) begin
        got.push_back({tuser, tlast, tdata});
      end
      // Random stalls make the output hold its beat across idle edges.
      tready <= !holdOff && ($random(seed) % 3 != 0);
    end
  end
endmodule

// [rtl/vlc_blend_lane.sv]
// One pixel lane of the layer blender, logo blend and optional RGB to YUV conversion.
// Assumes components ordered G, B, R in the low, middle and high fields.
`timescale 1ns/10ps
module vlc_blend_lane import vlc_pkg::*; #(
  parameter int NL = 8,
  parameter int BPC = 8,
  parameter bit CSC_EN = 1'b1
) (
  input wire logic [NL*3*BPC-1:0] layerPix,
  input wire logic [NL*8-1:0] layerAlpha,
  input wire logic [NL-1:0] layerUse,
  input wire logic [3*BPC-1:0] bgPix,
  input wire logic [3*BPC-1:0] logoPix,
  input wire logic [7:0] logoAlpha,
  input wire logic logoUse,
  input wire logic yuvOut,
  output logic [3*BPC-1:0] outPix
);
  localparam logic [BPC+8:0] K77 = (BPC+9)'(77), K150 = (BPC+9)'(150);
  localparam logic [BPC+8:0] K29 = (BPC+9)'(29), K128 = (BPC+9)'(128);
  localparam logic [BPC+8:0] K43 = (BPC+9)'(43), K85 = (BPC+9)'(85);
  localparam logic [BPC+8:0] K107 = (BPC+9)'(107), K21 = (BPC+9)'(21);

  // ----------------------------------------------------------------
  // Convex mix, alpha 255 taken as full cover
  // ----------------------------------------------------------------
  function automatic logic [BPC-1:0] mix(input logic [BPC-1:0] u, input logic [BPC-1:0] l,
                                         input logic [7:0] a);
    logic [BPC+9:0] uu, ll, a9, s;
    uu = (BPC+10)'(u);
    ll = (BPC+10)'(l);
    a9 = (BPC+10)'(a) + (BPC+10)'(a[7]);
    s = uu * a9 + ll * ((BPC+10)'(256) - a9) + (BPC+10)'(128);
    return s[BPC+7:8];
  endfunction

  // ----------------------------------------------------------------
  // Layer stack
  // ----------------------------------------------------------------
  always_comb begin
    logic [3*BPC-1:0] acc;
    logic [BPC+8:0] r9, g9, b9, mx;
    acc = bgPix;
    for (int l = 0; l < NL; l++) begin
      if (layerUse[l]) begin
        for (int c = 0; c < 3; c++) begin
          acc[c*BPC +: BPC] = mix(layerPix[(l*3+c)*BPC +: BPC], acc[c*BPC +: BPC],
                                  layerAlpha[l*8 +: 8]);
        end
      end
    end
    if (logoUse) begin
      for (int c = 0; c < 3; c++) begin
        acc[c*BPC +: BPC] = mix(logoPix[c*BPC +: BPC], acc[c*BPC +: BPC], logoAlpha);
      end
    end
    g9 = (BPC+9)'(acc[BPC-1:0]);
    b9 = (BPC+9)'(acc[2*BPC-1:BPC]);
    r9 = (BPC+9)'(acc[3*BPC-1:2*BPC]);
    mx = (BPC+9)'({BPC{1'b1}});
    outPix = acc;
    // Full-range conversion written with only positive terms to avoid signed arithmetic.
    if (CSC_EN && yuvOut) begin
      outPix[BPC-1:0] = BPC'((r9 * K77 + g9 * K150 + b9 * K29) >> 8);
      outPix[2*BPC-1:BPC] = BPC'((b9 * K128 + (mx - r9) * K43 + (mx - g9) * K85) >> 8);
      outPix[3*BPC-1:2*BPC] = BPC'((r9 * K128 + (mx - g9) * K107 + (mx - b9) * K21) >> 8);
    end
  end
endmodule

// [rtl/vlc_compositor.sv]
// Top of the video layer compositor: stream inputs, upscaling, logo store, AXI4-Lite slave.
// Assumes one clock for all interfaces and upstream streams that follow AXI4-Stream video.
// Notes on behaviour
// - Blend up to eight layers plus logo.
// - Non-primary layers built as stream inputs.
// - Optional RGB to YUV output conversion.
// - Logo kept in on-chip RAM, blended topmost.
// - Logo pixels matching colour key are transparent.
// - Logo uses global or per-pixel alpha.
// - Fixed depth order, convex blend with layers below.
// - Blend amount changeable live; global alpha per layer.
// - Per-pixel alpha from alpha-carrying formats.
// - Upscale layers 1x, 2x, 4x by repetition.
// - Three components, 8 to 16 bits, parallel pixels.
// - No input valid: output stops after draining.
// - No output ready: input stops when full.
// - One, two or four pixels per cycle.
// - Flush after each line, input ready low; only s_axis_tready, not the extra layer readies.
// - Ports follow configured layers.
// - All inputs sampled on rising core clock; rst_n acts asynchronously, not on the clock edge.
// - Reset low resets the whole device; logo RAM and line buffers keep their contents.
// - User flags frame start, last flags line end.
//
// The address map and register access over AXI4-Lite were decided locally.
`timescale 1ns/10ps
`include "vlc_map.svh"
module vlc_compositor import vlc_pkg::*; #(
  parameter int NL = 8,
  parameter int PPC = 1,
  parameter int BPC = 8,
  parameter int MAX_BEATS = 4096,
  parameter int LOGO_W = 64,
  parameter int LOGO_H = 64,
  parameter bit LOGO_EN = 1'b1,
  parameter bit CSC_EN = 1'b1,
  parameter int AW = 16
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [((3*BPC*PPC+7)/8)*8-1:0] s_axis_tdata,
  input wire logic s_axis_tvalid,
  output logic s_axis_tready,
  input wire logic s_axis_tuser,
  input wire logic s_axis_tlast,
  input wire logic [(NL-1)*(((4*BPC*PPC+7)/8)*8)-1:0] extra_layer_stream_in_tdata,
  input wire logic [NL-2:0] extra_layer_stream_in_tvalid,
  output logic [NL-2:0] extra_layer_stream_in_tready,
  input wire logic [NL-2:0] extra_layer_stream_in_tuser,
  input wire logic [NL-2:0] extra_layer_stream_in_tlast,
  output logic [((3*BPC*PPC+7)/8)*8-1:0] m_axis_tdata,
  output logic m_axis_tvalid,
  input wire logic m_axis_tready,
  output logic m_axis_tuser,
  output logic m_axis_tlast,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int DW3 = ((3*BPC*PPC+7)/8)*8;
  localparam int DW4 = ((4*BPC*PPC+7)/8)*8;
  localparam int EW = DW4 + 2;
  localparam int LW = 3*BPC;
  localparam int XW = $clog2(MAX_BEATS);
  localparam int LIW = $clog2(LOGO_W*LOGO_H);

  typedef struct packed {
    logic [NL-1:0][1:0][EW-1:0] fd;
    logic [NL-1:0][1:0] fc;
    logic [NL-1:0] rdy;
    vlc_state_e st;
    logic [7:0] fl;
    logic [15:0] xb, yl, frames;
    logic ov, ou, ol;
    logic [DW3-1:0] od;
    logic awr, wr, arr, awg, wg, bv, rv;
    logic [AW-1:0] awa;
    logic [31:0] wd, rd;
    logic [3:0] ws;
    logic [1:0] br, rr;
    logic [3:0] ctrl;
    logic [31:0] bg01, bg2, lpos;
    logic [NL-1:0] len;
    logic [23:0] key;
    logic [7:0] la;
    logic [NL-1:0][10:0] lcfg;
  } vlc_regs_s;

  vlc_regs_s q, d;
  logic [NL-1:0] need, pop;
  logic [NL-1:0][DW4-1:0] lyPix;
  logic go, headUser, headLast;
  logic [15:0] curX, curY;
  logic [PPC*LW-1:0] laneOut;
  logic [PPC-1:0] laneLogo;
  logic [31:0] logoRam [LOGO_W*LOGO_H];
  logic [DW4-1:0] lineBuf [NL][MAX_BEATS];

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  function automatic logic [15:0] scMask(input logic [1:0] sc);
    return (sc == VLC_SC4) ? 16'h0003 : (sc == VLC_SC2) ? 16'h0001 : 16'h0000;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      if (s[b]) o[b*8 +: 8] = n[b*8 +: 8];
    end
    return o;
  endfunction

  function automatic logic isReg(input logic [AW-1:0] a);
    return a < AW'(`VLC_REGS_END) && a[1:0] == 2'b00;
  endfunction

  function automatic logic isLogo(input logic [AW-1:0] a);
    return LOGO_EN && 32'(a) >= 32'(`VLC_LOGO_OFS) &&
           32'(a) < 32'(`VLC_LOGO_OFS) + 32'(4*LOGO_W*LOGO_H);
  endfunction

  // ----------------------------------------------------------------
  // Layer scheduling and upscaling
  // ----------------------------------------------------------------
  assign headUser = q.fd[0][0][EW-2];
  assign headLast = q.fd[0][0][EW-1];
  assign curX = headUser ? 16'h0000 : q.xb;
  assign curY = headUser ? 16'h0000 : q.yl;

  always_comb begin
    logic [15:0] m;
    m = 16'h0000;
    go = q.fc[0] != 2'd0 && (!q.ov || m_axis_tready);
    need = '0;
    pop = '0;
    need[0] = 1'b1;
    lyPix[0] = q.fd[0][0][DW4-1:0];
    for (int l = 1; l < NL; l++) begin
      m = scMask(q.lcfg[l][`VLC_LCFG_SC +: 2]);
      need[l] = q.len[l] && (curY & m) == 16'h0000;
      if (need[l] && q.fc[l] == 2'd0) go = 1'b0;
      lyPix[l] = need[l] ? q.fd[l][0][DW4-1:0] :
                 lineBuf[l][XW'(curX >> q.lcfg[l][`VLC_LCFG_SC +: 2])];
    end
    pop[0] = go;
    for (int l = 1; l < NL; l++) begin
      m = scMask(q.lcfg[l][`VLC_LCFG_SC +: 2]);
      pop[l] = go && need[l] && ((curX & m) == m || headLast);
    end
  end

  for (genvar l = 1; l < NL; l++) begin : g_line
    always_ff @(posedge ref_clk) begin
      if (go && need[l]) begin
        lineBuf[l][XW'(curX >> q.lcfg[l][`VLC_LCFG_SC +: 2])] <= q.fd[l][0][DW4-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Logo store and per-lane blending
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (q.awg && q.wg && !q.bv && isLogo(q.awa)) begin
      logoRam[LIW'((32'(q.awa) - 32'(`VLC_LOGO_OFS)) >> 2)] <= q.wd;
    end
  end

  for (genvar p = 0; p < PPC; p++) begin : g_lane
    logic [15:0] gx, lx, ly;
    logic [31:0] lw;
    logic hit;
    logic [NL*LW-1:0] lp;
    logic [NL*8-1:0] la;
    logic [LW-1:0] lgp;
    assign gx = 16'(32'(curX) * PPC + p);
    assign lx = gx - q.lpos[15:0];
    assign ly = curY - q.lpos[31:16];
    assign hit = gx >= q.lpos[15:0] && curY >= q.lpos[31:16] &&
                 lx < 16'(LOGO_W) && ly < 16'(LOGO_H);
    assign lw = logoRam[LIW'(32'(ly) * LOGO_W + 32'(lx))];
    assign laneLogo[p] = LOGO_EN && q.ctrl[`VLC_CTRL_LOGO] && hit && lw[23:0] != q.key;
    for (genvar c = 0; c < 3; c++) begin : g_comp
      assign lgp[c*BPC +: BPC] = BPC'(lw[c*8 +: 8]) << (BPC - 8);
    end
    for (genvar l = 0; l < NL; l++) begin : g_layer
      localparam int CP = (l == 0) ? 3 : 4;
      assign lp[l*LW +: LW] = lyPix[l][p*CP*BPC +: LW];
      assign la[l*8 +: 8] = (l > 0 && q.lcfg[l][`VLC_LCFG_PPA]) ?
                            lyPix[l][(p*4+3)*BPC + BPC - 8 +: 8] : q.lcfg[l][7:0];
    end
    vlc_blend_lane #(.NL(NL), .BPC(BPC), .CSC_EN(CSC_EN)) u_lane (
      .layerPix(lp),
      .layerAlpha(la),
      .layerUse(q.len),
      .bgPix({q.bg2[BPC-1:0], q.bg01[16 +: BPC], q.bg01[BPC-1:0]}),
      .logoPix(lgp),
      .logoAlpha(q.ctrl[`VLC_CTRL_LPPA] ? lw[31:24] : q.la),
      .logoUse(laneLogo[p]),
      .yuvOut(q.ctrl[`VLC_CTRL_YUV]),
      .outPix(laneOut[p*LW +: LW])
    );
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic push;
    logic [EW-1:0] ent;
    logic [2:0] li;
    push = 1'b0;
    ent = '0;
    li = 3'd0;
    d = q;
    for (int l = 0; l < NL; l++) begin
      if (l == 0) begin
        push = q.rdy[0] && s_axis_tvalid;
        ent = {s_axis_tlast, s_axis_tuser, DW4'(s_axis_tdata)};
      end else begin
        push = q.rdy[l] && extra_layer_stream_in_tvalid[l-1];
        ent = {extra_layer_stream_in_tlast[l-1], extra_layer_stream_in_tuser[l-1],
               extra_layer_stream_in_tdata[(l-1)*DW4 +: DW4]};
      end
      if (pop[l]) begin
        d.fd[l][0] = q.fd[l][1];
        d.fc[l] = d.fc[l] - 2'd1;
      end
      if (push) begin
        d.fd[l][d.fc[l][0]] = ent;
        d.fc[l] = d.fc[l] + 2'd1;
      end
    end
    if (q.ov && m_axis_tready) d.ov = 1'b0;
    if (go) begin
      d.ov = 1'b1;
      d.od = DW3'(laneOut);
      d.ou = headUser;
      d.ol = headLast;
      d.xb = headLast ? 16'h0000 : curX + 16'h0001;
      d.yl = headLast ? curY + 16'h0001 : curY;
      if (headUser) d.frames = q.frames + 16'h0001;
    end
    unique case (q.st)
      VLC_STOP: begin
        if (q.ctrl[`VLC_CTRL_RUN]) d.st = VLC_RUN;
      end
      VLC_RUN: begin
        if (go && headLast) begin
          d.st = VLC_FLUSH;
          d.fl = `VLC_FLUSH_CYC;
        end else if (!q.ctrl[`VLC_CTRL_RUN]) begin
          d.st = VLC_STOP;
        end
      end
      VLC_FLUSH: begin
        d.fl = q.fl - 8'h01;
        if (q.fl == 8'h01) d.st = VLC_RUN;
      end
    endcase
    for (int l = 0; l < NL; l++) begin
      d.rdy[l] = d.fc[l] != 2'd2 && (l != 0 || d.st == VLC_RUN);
    end
    // Write address and data are taken separately; the write happens once both are held.
    if (q.awr && s_axi_awvalid) begin
      d.awg = 1'b1;
      d.awa = s_axi_awaddr;
    end
    if (q.wr && s_axi_wvalid) begin
      d.wg = 1'b1;
      d.wd = s_axi_wdata;
      d.ws = s_axi_wstrb;
    end
    if (q.bv && s_axi_bready) d.bv = 1'b0;
    if (q.awg && q.wg && !q.bv) begin
      d.awg = 1'b0;
      d.wg = 1'b0;
      d.bv = 1'b1;
      d.br = (isReg(q.awa) || isLogo(q.awa)) ? `VLC_RESP_OK : `VLC_RESP_ERR;
      li = q.awa[4:2];
      case (q.awa)
        AW'(`VLC_CTRL_OFS): d.ctrl = 4'(merge(32'(q.ctrl), q.wd, q.ws));
        AW'(`VLC_BG01_OFS): d.bg01 = merge(q.bg01, q.wd, q.ws);
        AW'(`VLC_BG2_OFS): d.bg2 = merge(q.bg2, q.wd, q.ws);
        AW'(`VLC_LEN_OFS): d.len = NL'(merge(32'(q.len), q.wd, q.ws));
        AW'(`VLC_KEY_OFS): d.key = 24'(merge(32'(q.key), q.wd, q.ws));
        AW'(`VLC_LALPHA_OFS): d.la = 8'(merge(32'(q.la), q.wd, q.ws));
        AW'(`VLC_LPOS_OFS): d.lpos = merge(q.lpos, q.wd, q.ws);
        default: begin
          if (isReg(q.awa) && q.awa >= AW'(`VLC_LCFG_OFS) && 32'(li) < NL) begin
            d.lcfg[li] = 11'(merge(32'(q.lcfg[li]), q.wd, q.ws));
          end
        end
      endcase
    end
    d.awr = !d.awg && !d.bv;
    d.wr = !d.wg && !d.bv;
    if (q.rv && s_axi_rready) d.rv = 1'b0;
    if (q.arr && s_axi_arvalid) begin
      d.rv = 1'b1;
      d.rr = isReg(s_axi_araddr) || isLogo(s_axi_araddr) ? `VLC_RESP_OK : `VLC_RESP_ERR;
      li = s_axi_araddr[4:2];
      case (s_axi_araddr)
        AW'(`VLC_CTRL_OFS): d.rd = 32'(q.ctrl);
        AW'(`VLC_STAT_OFS): d.rd = {q.frames, 14'h0000, q.st == VLC_FLUSH, q.st != VLC_STOP};
        AW'(`VLC_BG01_OFS): d.rd = q.bg01;
        AW'(`VLC_BG2_OFS): d.rd = q.bg2;
        AW'(`VLC_LEN_OFS): d.rd = 32'(q.len);
        AW'(`VLC_KEY_OFS): d.rd = 32'(q.key);
        AW'(`VLC_LALPHA_OFS): d.rd = 32'(q.la);
        AW'(`VLC_LPOS_OFS): d.rd = q.lpos;
        default: begin
          d.rd = (isReg(s_axi_araddr) && s_axi_araddr >= AW'(`VLC_LCFG_OFS) && 32'(li) < NL) ?
                 32'(q.lcfg[li]) : 32'h0000_0000;
        end
      endcase
    end
    d.arr = !d.rv;
  end

  // Reset takes the whole state to zero: no layer enabled, stopped, all readies low.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= vlc_regs_s'(`VLC_REG_RST);
    end else begin
      q <= d;
    end
  end

  assign s_axis_tready = q.rdy[0];
  assign extra_layer_stream_in_tready = q.rdy[NL-1:1];
  assign m_axis_tdata = q.od;
  assign m_axis_tvalid = q.ov;
  assign m_axis_tuser = q.ou;
  assign m_axis_tlast = q.ol;
  assign s_axi_awready = q.awr;
  assign s_axi_wready = q.wr;
  assign s_axi_bvalid = q.bv;
  assign s_axi_bresp = q.br;
  assign s_axi_arready = q.arr;
  assign s_axi_rvalid = q.rv;
  assign s_axi_rdata = q.rd;
  assign s_axi_rresp = q.rr;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  flush_ready_a: assert property (q.st == VLC_FLUSH |-> !s_axis_tready)
    else $error("input ready high during flush");
  line_flush_a: assert property (go && headLast && q.st == VLC_RUN |=>
    (q.st == VLC_FLUSH)[*4] ##1 q.st == VLC_RUN)
    else $error("flush length wrong after line end");
  out_hold_a: assert property (m_axis_tvalid && !m_axis_tready |=>
    m_axis_tvalid && $stable(m_axis_tdata) && $stable(m_axis_tlast))
    else $error("output changed while stalled");
  full_stall_a: assert property (q.fc[0] == 2'd2 |-> !s_axis_tready)
    else $error("input ready while full");
  drain_stop_a: assert property (q.fc[0] == 2'd0 && !m_axis_tvalid |=> !m_axis_tvalid)
    else $error("output valid without input");
  bg_fill_a: assert property (go && q.len == '0 && q.ctrl[`VLC_CTRL_LOGO] == 1'b0 &&
    q.ctrl[`VLC_CTRL_YUV] == 1'b0 |=> m_axis_tdata[LW-1:0] ==
    $past({q.bg2[BPC-1:0], q.bg01[16 +: BPC], q.bg01[BPC-1:0]}))
    else $error("uncovered pixel not background");
  sof_pass_a: assert property (go && headUser |=> m_axis_tuser && m_axis_tvalid)
    else $error("frame start flag lost");
  beat_rate_a: assert property (q.len == NL'(1) && q.fc[0] != 2'd0 && !q.ov |-> go)
    else $error("ready beat not processed");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  frame_c: cover property (go && headUser);
  flush_c: cover property (q.st == VLC_RUN ##1 q.st == VLC_FLUSH);
  logo_c: cover property (go && laneLogo[0]);
endmodule

// [rtl/vlc_map.svh]
// Register offsets, field positions, reset values and timing counts of the compositor.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
`ifndef VLC_MAP_SVH
`define VLC_MAP_SVH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define VLC_CTRL_OFS 16'h0000
`define VLC_STAT_OFS 16'h0004
`define VLC_BG01_OFS 16'h0008
`define VLC_BG2_OFS 16'h000C
`define VLC_LEN_OFS 16'h0010
`define VLC_KEY_OFS 16'h0014
`define VLC_LALPHA_OFS 16'h0018
`define VLC_LPOS_OFS 16'h001C
`define VLC_LCFG_OFS 16'h0020
`define VLC_REGS_END 16'h0040
`define VLC_LOGO_OFS 16'h1000
// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define VLC_CTRL_RUN 0
`define VLC_CTRL_LOGO 1
`define VLC_CTRL_LPPA 2
`define VLC_CTRL_YUV 3
`define VLC_LCFG_PPA 8
`define VLC_LCFG_SC 9
`define VLC_REG_RST 32'h0000_0000
// ----------------------------------------------------------------
// Timing counts and bus answers
// ----------------------------------------------------------------
`define VLC_FLUSH_CYC 8'h04
`define VLC_RESP_OK 2'b00
`define VLC_RESP_ERR 2'b10
`endif

// [rtl/vlc_pkg.sv]
// Types shared by the compositor modules.
// Assumes the constants of vlc_map.svh for all numeric values.
package vlc_pkg;
  // ----------------------------------------------------------------
  // Frame sequencing and upscale factors
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    VLC_STOP = 2'b00,
    VLC_RUN = 2'b01,
    VLC_FLUSH = 2'b11
  } vlc_state_e;
  typedef enum logic [1:0] {
    VLC_SC1 = 2'b00,
    VLC_SC2 = 2'b01,
    VLC_SC4 = 2'b10
  } vlc_scale_e;
endpackage
